/* File: verilog/erc_pkg.sv */
// Functional notes
// - Enable in normal mode selects stand-alone
// - Load-share bit selects load-sharing configuration
// - First enable or share bit locks configuration
// - Lock survives soft reset, cleared at power-down
// - Voltage select, stand-alone only: clear 5.0V, set 3.3V
// - Stop mode: high stage follows current hysteresis
// - Normal mode: only high-power stage active
// - Supply low turns rail off unless keep-on
// - Rail off in init and fail-safe
// - Sharing follows main: restart on, sleep off
// - Stand-alone rail fixed outside normal mode
// - Stop mode drops sharing unless keep bit
// - Sharing resumes on return to normal
// - Stand-alone change attempt ignored, no failure
// - Sharing change attempt raises serial failure
// - Overcurrent sets flag only, clearable after
// - Stand-alone rail undervoltage sets flag
// - Sharing raises no rail flags
// - Sharing rail shut in fail-safe
package erc_pkg;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [2:0] {
    ERC_MODE_INIT     = 3'h0,
    ERC_MODE_NORMAL   = 3'h1,
    ERC_MODE_STOP     = 3'h3,
    ERC_MODE_SLEEP    = 3'h2,
    ERC_MODE_RESTART  = 3'h6,
    ERC_MODE_FAILSAFE = 3'h7
  } erc_mode_type;

  // ----------------------------------------
  // Configuration states
  // ----------------------------------------
  typedef enum logic [1:0] {
    ERC_CFG_NONE  = 2'h0,
    ERC_CFG_ALONE = 2'h1,
    ERC_CFG_SHARE = 2'h3
  } erc_cfg_type;

  // ----------------------------------------
  // Control write bundle
  // ----------------------------------------
  typedef struct packed {
    logic aux_rail_enable;
    logic load_share_select;
    logic rail_voltage_select;
    logic share_keep_in_stop;
    logic keep_on_at_supply_low;
  } erc_ctrl_type;

  localparam logic       VSEL_5V0      = 1'h0;
  localparam logic       VSEL_3V3      = 1'h1;
  localparam logic [1:0] SUP_FILT_INIT = 2'h0;

endpackage : erc_pkg

/* File: verilog/erc_filt.sv */
`timescale 1ns/10ps
`default_nettype none
module erc_filt #(
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire  logic clk_sys,
  input  wire  logic rst,
  input  wire  logic clk_en,
  // Level in and out
  input  wire  logic level_in,
  output logic       level_out
);

  initial begin
    if (DEPTH < 2) begin
      $error("erc_filt: DEPTH must be at least 2");
    end
  end

  // ----------------------------------------
  // Agreement filter
  // ----------------------------------------
  // Comparator outputs chatter near threshold; DEPTH equal samples change the level
  logic [DEPTH-1:0] hist_reg;
  logic [DEPTH-1:0] hist_next;
  logic             all_one;
  logic             all_zero;

  assign hist_next = {hist_reg[DEPTH-2:0], level_in};
  assign all_one   = &hist_reg;
  assign all_zero  = ~|hist_reg;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hist_reg  <= '0;
      level_out <= 1'b0;
    end else if (clk_en) begin
      hist_reg <= hist_next;
      if (all_one) begin
        level_out <= 1'b1;
      end else if (all_zero) begin
        level_out <= 1'b0;
      end
    end
  end

endmodule : erc_filt
`default_nettype wire

/* File: verilog/erc_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module erc_ctrl #(
  parameter int unsigned FILT_DEPTH = 2
) (
  // Clock and resets; rst is power-on only
  input  wire  logic                  clk_sys,
  input  wire  logic                  rst,
  input  wire  logic                  soft_rst,
  input  wire  logic                  clk_en,
  // Operating mode
  input  wire  erc_pkg::erc_mode_type op_mode,
  // Control write
  input  wire  logic                  ctrl_wr,
  input  wire  erc_pkg::erc_ctrl_type ctrl_data,
  input  wire  logic                  oc_flag_clr,
  input  wire  logic                  uv_flag_clr,
  // Analog sense
  input  wire  logic                  drive_above_upper,
  input  wire  logic                  drive_below_lower,
  input  wire  logic                  supply_below_uv,
  input  wire  logic                  shunt_at_threshold,
  input  wire  logic                  rail_below_uv,
  // Rail control
  output logic                        rail_on,
  output logic                        share_active,
  output logic                        volt_3v3_sel,
  output logic                        hp_stage_on,
  output logic                        lp_stage_on,
  // Status
  output logic                        cfg_locked,
  output erc_pkg::erc_cfg_type        cfg_state,
  output logic                        rail_overcurrent_flag,
  output logic                        rail_undervoltage_flag,
  output logic                        serial_fail_pulse
);

  initial begin
    if (FILT_DEPTH < 2) begin
      $error("erc_ctrl: FILT_DEPTH must be at least 2");
    end
  end

  // ----------------------------------------
  // Supply low filter
  // ----------------------------------------
  logic supply_low;

  erc_filt #(
    .DEPTH(FILT_DEPTH)
  ) u_supply_filt (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .clk_en   (clk_en),
    .level_in (supply_below_uv),
    .level_out(supply_low)
  );

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  function automatic logic is_mode(input erc_pkg::erc_mode_type m,
                                   input erc_pkg::erc_mode_type want);
    is_mode = (m == want);
  endfunction : is_mode

  erc_pkg::erc_cfg_type cfg_reg;
  erc_pkg::erc_cfg_type cfg_next;
  logic                 en_reg;
  logic                 en_next;
  logic                 vsel_reg;
  logic                 keep_stop_reg;
  logic                 keep_uv_reg;
  logic                 hp_reg;
  logic                 hp_next;
  logic                 oc_next;
  logic                 uv_next;
  logic                 fail_next;
  logic                 rail_next;
  logic                 share_next;
  wire  logic           in_normal;
  wire  logic           in_stop;
  wire  logic           in_sleep;
  wire  logic           in_restart;
  wire  logic           in_off_mode;
  wire  logic           is_alone;
  wire  logic           is_share;
  wire  logic           unlocked;
  wire  logic           wr_normal;
  wire  logic           try_share;
  wire  logic           try_alone;
  wire  logic           share_run;
  wire  logic           alone_run;
  wire  logic           uv_cut;

  assign in_normal   = is_mode(op_mode, erc_pkg::ERC_MODE_NORMAL);
  assign in_stop     = is_mode(op_mode, erc_pkg::ERC_MODE_STOP);
  assign in_sleep    = is_mode(op_mode, erc_pkg::ERC_MODE_SLEEP);
  assign in_restart  = is_mode(op_mode, erc_pkg::ERC_MODE_RESTART);
  assign in_off_mode = is_mode(op_mode, erc_pkg::ERC_MODE_INIT)
                     | is_mode(op_mode, erc_pkg::ERC_MODE_FAILSAFE);
  assign is_alone    = (cfg_reg == erc_pkg::ERC_CFG_ALONE);
  assign is_share    = (cfg_reg == erc_pkg::ERC_CFG_SHARE);
  assign unlocked    = (cfg_reg == erc_pkg::ERC_CFG_NONE);
  assign wr_normal   = ctrl_wr & in_normal;
  assign try_share   = ctrl_data.load_share_select;
  assign try_alone   = ctrl_data.aux_rail_enable & ~ctrl_data.load_share_select;

  // ----------------------------------------
  // Configuration lock
  // ----------------------------------------
  // Load-share is taken from any mode; stand-alone only from normal mode
  always_comb begin
    cfg_next = cfg_reg;
    if (unlocked && ctrl_wr && try_share) begin
      cfg_next = erc_pkg::ERC_CFG_SHARE;
    end else if (unlocked && wr_normal && try_alone) begin
      cfg_next = erc_pkg::ERC_CFG_ALONE;
    end
  end

  // Attempts to leave sharing: share bit cleared or enable bit raised
  always_comb begin
    fail_next = 1'b0;
    if (is_share && ctrl_wr) begin
      fail_next = ~ctrl_data.load_share_select | ctrl_data.aux_rail_enable;
    end
  end

  // Stand-alone: enable switches the rail; a share request is dropped silently
  always_comb begin
    en_next = en_reg;
    if (wr_normal && (unlocked || is_alone) && !(unlocked && try_share)) begin
      en_next = ctrl_data.aux_rail_enable;
    end
  end

  // ----------------------------------------
  // Rail state by mode
  // ----------------------------------------
  assign uv_cut    = supply_low & ~keep_uv_reg;
  assign share_run = in_normal | in_restart | (in_stop & keep_stop_reg);
  assign alone_run = en_reg & ~in_off_mode;

  always_comb begin
    rail_next  = 1'b0;
    share_next = 1'b0;
    if (in_off_mode || uv_cut) begin
      rail_next  = 1'b0;
      share_next = 1'b0;
    end else if (is_share) begin
      rail_next  = share_run & ~in_sleep;
      share_next = share_run & ~in_sleep;
    end else if (is_alone) begin
      rail_next  = alone_run;
    end
  end

  // ----------------------------------------
  // Regulator stages
  // ----------------------------------------
  always_comb begin
    hp_next = hp_reg;
    if (!rail_next) begin
      hp_next = 1'b0;
    end else if (!in_stop) begin
      hp_next = 1'b1;
    end else if (drive_above_upper) begin
      hp_next = 1'b1;
    end else if (drive_below_lower) begin
      hp_next = 1'b0;
    end
  end

  // ----------------------------------------
  // Flags
  // ----------------------------------------
  // Set beats clear; clear needs the condition gone
  always_comb begin
    oc_next = rail_overcurrent_flag;
    if (is_alone && rail_on && shunt_at_threshold) begin
      oc_next = 1'b1;
    end else if (oc_flag_clr) begin
      oc_next = 1'b0;
    end
    if (!is_alone) begin
      oc_next = 1'b0;
    end
  end

  always_comb begin
    uv_next = rail_undervoltage_flag;
    if (is_alone && rail_on && rail_below_uv) begin
      uv_next = 1'b1;
    end else if (uv_flag_clr) begin
      uv_next = 1'b0;
    end
    if (!is_alone) begin
      uv_next = 1'b0;
    end
  end

  // ----------------------------------------
  // Lock state: power-on reset only
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cfg_reg    <= erc_pkg::ERC_CFG_NONE;
      cfg_locked <= 1'b0;
    end else if (clk_en) begin
      cfg_reg    <= cfg_next;
      cfg_locked <= (cfg_next != erc_pkg::ERC_CFG_NONE);
    end
  end

  // ----------------------------------------
  // Soft-resettable state
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      en_reg        <= 1'b0;
      vsel_reg      <= erc_pkg::VSEL_5V0;
      keep_stop_reg <= 1'b0;
      keep_uv_reg   <= 1'b0;
    end else if (clk_en) begin
      if (soft_rst) begin
        en_reg        <= 1'b0;
        vsel_reg      <= erc_pkg::VSEL_5V0;
        keep_stop_reg <= 1'b0;
        keep_uv_reg   <= 1'b0;
      end else begin
        en_reg <= en_next;
        if (ctrl_wr) begin
          vsel_reg      <= ctrl_data.rail_voltage_select;
          keep_stop_reg <= ctrl_data.share_keep_in_stop;
          keep_uv_reg   <= ctrl_data.keep_on_at_supply_low;
        end
      end
    end
  end

  // ----------------------------------------
  // Output registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rail_on                <= 1'b0;
      share_active           <= 1'b0;
      volt_3v3_sel           <= 1'b0;
      hp_reg                 <= 1'b0;
      lp_stage_on            <= 1'b0;
      rail_overcurrent_flag  <= 1'b0;
      rail_undervoltage_flag <= 1'b0;
      serial_fail_pulse      <= 1'b0;
    end else if (clk_en) begin
      rail_on                <= rail_next;
      share_active           <= share_next;
      volt_3v3_sel           <= is_alone & (vsel_reg == erc_pkg::VSEL_3V3);
      hp_reg                 <= hp_next;
      lp_stage_on            <= rail_next & ~in_normal;
      rail_overcurrent_flag  <= oc_next;
      rail_undervoltage_flag <= uv_next;
      serial_fail_pulse      <= fail_next;
    end
  end

  assign hp_stage_on = hp_reg;
  assign cfg_state   = cfg_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_share_stop;
    is_share && in_stop && !keep_stop_reg && !in_off_mode;
  endsequence

  a_lock_holds: assert property (@(posedge clk_sys) disable iff (rst)
    (!unlocked && clk_en) |=> $stable(cfg_reg))
    else $error("locked configuration changed");

  a_both_bits_share: assert property (@(posedge clk_sys) disable iff (rst)
    (unlocked && clk_en && ctrl_wr && try_share && ctrl_data.aux_rail_enable)
      |=> is_share)
    else $error("both bits did not choose sharing");

  a_off_modes: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && in_off_mode) |=> !rail_on && !share_active)
    else $error("rail on in off mode");

  a_supply_cut: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && supply_low && !keep_uv_reg) |=> !rail_on)
    else $error("rail on at supply low");

  a_share_stop_off: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en and s_share_stop) |=> !share_active && is_share)
    else $error("sharing kept in stop");

  a_share_fail: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && is_share && ctrl_wr && !ctrl_data.load_share_select)
      |=> serial_fail_pulse && is_share)
    else $error("sharing change not flagged");

  a_alone_no_fail: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && is_alone) |=> !serial_fail_pulse)
    else $error("stand-alone raised failure");

  a_share_no_flags: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && is_share) |=> !rail_overcurrent_flag && !rail_undervoltage_flag)
    else $error("sharing raised rail flag");

  a_normal_stage: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && in_normal && rail_next) |=> hp_stage_on && !lp_stage_on)
    else $error("wrong stage in normal mode");

  a_oc_set: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && is_alone && rail_on && shunt_at_threshold) |=> rail_overcurrent_flag)
    else $error("overcurrent flag not set");

  a_hyst_rise: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && in_stop && rail_next && drive_above_upper) |=> hp_stage_on)
    else $error("high stage not raised in stop");

  a_hyst_fall: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && in_stop && rail_next && !drive_above_upper && drive_below_lower)
      |=> !hp_stage_on)
    else $error("high stage not dropped in stop");

  a_share_no_vsel: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && is_share) |=> !volt_3v3_sel)
    else $error("voltage select used while sharing");

  a_soft_keeps_lock: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && soft_rst && !unlocked) |=> cfg_locked)
    else $error("soft reset released lock");

  a_rail_recover: assert property (@(posedge clk_sys) disable iff (rst)
    (clk_en && is_alone && en_reg && in_normal && !uv_cut) |=> rail_on)
    else $error("rail not back on after supply recovery");

  // Two steps: a stop cycle in the sharing configuration, then back in normal mode
  sequence s_stop_to_normal;
    (clk_en && is_share && in_stop) ##1 (clk_en && in_normal && !uv_cut);
  endsequence

  a_share_resume: assert property (@(posedge clk_sys) disable iff (rst)
    s_stop_to_normal |=> share_active)
    else $error("sharing not resumed after stop");

endmodule : erc_ctrl
`default_nettype wire

/* File: bench/erc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module erc_host (
  // Clock
  input  wire logic                  clk_sys,
  // Control write
  output var  logic                  ctrl_wr,
  output var  erc_pkg::erc_ctrl_type ctrl_data
);
  initial begin
    ctrl_wr   = 1'h0;
    ctrl_data = erc_pkg::erc_ctrl_type'(5'h00);
  end
  // Strobe lasts one cycle; data is inverted afterwards so no stale value lingers
  task automatic write(input logic [4:0] val);
    @(negedge clk_sys);
    ctrl_wr   = 1'h1;
    ctrl_data = erc_pkg::erc_ctrl_type'(val);
    @(negedge clk_sys);
    ctrl_wr   = 1'h0;
    ctrl_data = erc_pkg::erc_ctrl_type'(~val);
  endtask : write
endmodule : erc_host
`default_nettype wire

/* File: bench/erc_ctrl_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module erc_ctrl_bench;
  localparam int FD = 2;
  logic                  clk_sys, rst, soft_rst, clk_en, ocl, ucl;
  logic                  dau, dbl, sbu, sat, rbu;
  logic [4:0]            d;
  erc_pkg::erc_mode_type mode;
  wire logic             ctrl_wr, rail_on, share_on, v33, hp, lp, locked, ocf, uvf, fail;
  wire erc_pkg::erc_ctrl_type ctrl_data;
  wire erc_pkg::erc_cfg_type  cfg;
  int                    err_count, n_tests;
  erc_pkg::erc_mode_type ma [6];

  erc_host host (.clk_sys(clk_sys), .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data));
  erc_ctrl #(.FILT_DEPTH(FD)) dut (
    .clk_sys(clk_sys), .rst(rst), .soft_rst(soft_rst), .clk_en(clk_en), .op_mode(mode),
    .ctrl_wr(ctrl_wr), .ctrl_data(ctrl_data), .oc_flag_clr(ocl), .uv_flag_clr(ucl),
    .drive_above_upper(dau), .drive_below_lower(dbl), .supply_below_uv(sbu),
    .shunt_at_threshold(sat), .rail_below_uv(rbu), .rail_on(rail_on),
    .share_active(share_on), .volt_3v3_sel(v33), .hp_stage_on(hp), .lp_stage_on(lp),
    .cfg_locked(locked), .cfg_state(cfg), .rail_overcurrent_flag(ocf),
    .rail_undervoltage_flag(uvf), .serial_fail_pulse(fail));

  // ------
  // Helpers
  // ------
  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : tick
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // Rail state by mode: sharing follows the main rail, stand-alone stays on outside init and fail-safe
  function automatic logic exp_rail(input logic shr, input logic keep,
                                    input erc_pkg::erc_mode_type m);
    if (m == erc_pkg::ERC_MODE_INIT || m == erc_pkg::ERC_MODE_FAILSAFE) return 1'h0;
    if (!shr) return 1'h1;
    if (m == erc_pkg::ERC_MODE_STOP) return keep;
    return m != erc_pkg::ERC_MODE_SLEEP;
  endfunction : exp_rail

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    $display("watchdog expired");
    conclude();
  end

  // ------
  // Tests
  // ------
  initial begin
    {rst, soft_rst, ocl, ucl, dau, dbl, sbu, sat, rbu} = 9'h100;
    clk_en = 1'h1;
    mode   = erc_pkg::ERC_MODE_NORMAL;
    void'($urandom(90));
    tick(2);
    rst = 1'h0;
    tick(1);
    check("reset", {rail_on, locked, ocf, fail}, 4'h0);
    host.write(5'h10); // Configuration goes out right after power-up
    tick(2);
    check("cfg", {2'h0, cfg}, {2'h0, erc_pkg::ERC_CFG_ALONE});
    check("lock", {3'h0, locked}, 4'h1);
    check("stages", {1'h0, rail_on, hp, lp}, 4'h6);
    for (int i = 0; i < 6; i++) begin
      d = {2'h2, 1'($urandom), 2'h0};
      host.write(d);
      tick(2);
      check("vsel", {3'h0, v33}, {3'h0, d[2]});
    end
    host.write(5'h18);
    check("fail", {3'h0, fail}, 4'h0);
    tick(2);
    check("cfg", {2'h0, cfg}, {2'h0, erc_pkg::ERC_CFG_ALONE});
    host.write(5'h00);
    tick(2);
    check("off", {3'h0, rail_on}, 4'h0);
    soft_rst = 1'h1;
    tick(1);
    soft_rst = 1'h0;
    tick(2);
    check("soft", {locked, 1'h0, cfg}, {3'h4, 1'h1});
    host.write(5'h10);
    tick(2);
    ma = '{erc_pkg::ERC_MODE_STOP, erc_pkg::ERC_MODE_SLEEP, erc_pkg::ERC_MODE_RESTART,
           erc_pkg::ERC_MODE_INIT, erc_pkg::ERC_MODE_FAILSAFE, erc_pkg::ERC_MODE_NORMAL};
    foreach (ma[i]) begin
      mode = ma[i];
      tick(3);
      check("mode", {3'h0, rail_on}, {3'h0, exp_rail(1'h0, 1'h0, ma[i])});
    end
    mode = erc_pkg::ERC_MODE_STOP;
    dbl  = 1'h1;
    tick(3);
    check("hyst", {2'h0, hp, lp}, 4'h1);
    dbl = 1'h0;
    tick(3);
    check("hyst", {2'h0, hp, lp}, 4'h1);
    dau = 1'h1;
    tick(3);
    check("hyst", {2'h0, hp, lp}, 4'h3);
    dau = 1'h0;
    tick(3);
    check("hyst", {2'h0, hp, lp}, 4'h3);
    mode = erc_pkg::ERC_MODE_NORMAL;
    sbu  = 1'h1;
    tick(FD + 3);
    check("uvoff", {3'h0, rail_on}, 4'h0);
    sbu = 1'h0;
    tick(FD + 3);
    check("uvon", {3'h0, rail_on}, 4'h1);
    host.write(5'h11);
    sbu = 1'h1;
    tick(FD + 3);
    check("uvkeep", {3'h0, rail_on}, 4'h1);
    sbu = 1'h0;
    sat = 1'h1;
    rbu = 1'h1;
    tick(3);
    check("flags", {1'h0, rail_on, ocf, uvf}, 4'h7);
    ocl = 1'h1;
    tick(1);
    ocl = 1'h0;
    tick(2);
    check("ocheld", {3'h0, ocf}, 4'h1);
    {sat, rbu, ocl, ucl} = 4'h3;
    tick(1);
    {ocl, ucl} = 2'h0;
    tick(2);
    check("clear", {2'h0, ocf, uvf}, 4'h0);
    // Clock enable low: random noise on every input except rst and the control write must leave rail, lock and flags frozen
    clk_en = 1'h0;
    for (int i = 0; i < 8; i++) begin
      {soft_rst, ocl, ucl, dau, dbl, sbu, sat, rbu} = 8'($urandom);
      mode = ma[$urandom_range(5)];
      tick(1);
      check("frozen", {rail_on, locked, ocf, uvf}, 4'hc);
    end
    {soft_rst, ocl, ucl, dau, dbl, sbu, sat, rbu} = 8'h00;
    mode   = erc_pkg::ERC_MODE_NORMAL;
    clk_en = 1'h1;
    $display("test stand-alone done");
    rst = 1'h1;
    tick(2);
    rst = 1'h0;
    tick(1);
    check("por", {locked, 1'h0, cfg}, 4'h0);
    host.write(5'h1c);
    tick(2);
    check("both", {2'h0, cfg}, {2'h0, erc_pkg::ERC_CFG_SHARE});
    check("share", {1'h0, share_on, rail_on, v33}, 4'h6);
    for (int i = 0; i < 4; i++) begin
      d = {1'h1, 4'($urandom)};
      host.write(d);
      check("fail", {3'h0, fail}, 4'h1);
      tick(2);
      check("cfg", {2'h0, cfg}, {2'h0, erc_pkg::ERC_CFG_SHARE});
    end
    host.write(5'h08);
    check("fail", {3'h0, fail}, 4'h0);
    {sat, rbu} = 2'h3;
    tick(3);
    check("noflags", {2'h0, ocf, uvf}, 4'h0);
    {sat, rbu} = 2'h0;
    ma = '{erc_pkg::ERC_MODE_STOP, erc_pkg::ERC_MODE_NORMAL, erc_pkg::ERC_MODE_SLEEP,
           erc_pkg::ERC_MODE_RESTART, erc_pkg::ERC_MODE_FAILSAFE, erc_pkg::ERC_MODE_NORMAL};
    foreach (ma[i]) begin
      mode = ma[i];
      tick(3);
      check("smode", {3'h0, rail_on}, {3'h0, exp_rail(1'h1, 1'h0, ma[i])});
    end
    host.write(5'h0a);
    mode = erc_pkg::ERC_MODE_STOP;
    tick(3);
    check("keep", {1'h0, rail_on, cfg}, {2'h1, erc_pkg::ERC_CFG_SHARE});
    $display("test sharing done");
    conclude();
  end
endmodule : erc_ctrl_bench
`default_nettype wire
